// *** bench/modem_term.sv ***
`timescale 1ns/100ps
module modem_term (
  input  wire logic       mclk,
  output logic            rxd,
  output logic [3:0]      lines_n
);
  // ********
  // Far end: idles at mark, lines inactive high
  // ********
  initial {rxd, lines_n} = 5'h1f;
  // Start, data low bit first, parity slot, stop; 16 ticks a bit at divisor one
  task send(input logic [7:0] d, input logic p);
    logic [10:0] f;
    f = {1'b1, p, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (16) @(posedge mclk);
    end
  endtask : send
  task hold_low(input int n);
    rxd <= 1'b0;
    repeat (n) @(posedge mclk);
    rxd <= 1'b1;
    repeat (16) @(posedge mclk);
  endtask : hold_low
  // Waits out the input synchronisers
  task set_lines(input logic [3:0] v);
    lines_n <= v;
    repeat (4) @(posedge mclk);
  endtask : set_lines
endmodule : modem_term

// *** bench/test_uart_line_modem.sv ***
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module test_uart_line_modem;
  logic       mclk, arst_n, wr_stb, rd_stb, rxd, txd, irq_out, irq_oe;
  logic       terminal_ready_out_n, request_send_out_n;
  logic [2:0] addr;
  logic [3:0] lines_n;
  logic [7:0] wdata, rdata;
  int         err_total, comparisons, cyc;
  uart_line_modem i_uart_line_modem (.mclk, .arst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .txd, .rxd, .clear_send_in_n(lines_n[0]), .set_ready_in_n(lines_n[1]),
    .ring_in_n(lines_n[2]), .carrier_detect_in_n(lines_n[3]), .terminal_ready_out_n,
    .request_send_out_n, .irq_out, .irq_oe);
  modem_term i_modem_term (.mclk, .rxd, .lines_n);
  // ********
  // Bus cycles and scenarios
  // ********
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk) {addr, wdata, wr_stb} <= {a, d, 1'b1};
    @(posedge mclk) wr_stb <= 1'b0;
  endtask : wr
  task rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    @(posedge mclk) {addr, rd_stb} <= {a, 1'b1};
    @(posedge mclk) rd_stb <= 1'b0;
    #1 `CHK(rdata & m, e)
  endtask : rd
  task summarize;
    if (err_total == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task t_control;
    wr(3'h4, 8'hef);
    #1 `CHK({terminal_ready_out_n, request_send_out_n, irq_oe}, 3'b001)
    rd(3'h4, 8'h0f);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h01);
    rd(3'h0, 8'h01);
    wr(3'h3, 8'h40);
    #100 `CHK(txd, 1'b0)
    wr(3'h3, 8'h00);
    #100 `CHK(txd, 1'b1)
  endtask : t_control
  task t_modem;
    i_modem_term.set_lines(4'b1010);
    rd(3'h6, 8'h51);
    i_modem_term.set_lines(4'b1111);
    rd(3'h6, 8'h05);
    rd(3'h6, 8'h00);
  endtask : t_modem
  task t_loop;
    wr(3'h4, 8'h1f);
    #1 `CHK({terminal_ready_out_n, request_send_out_n}, 2'b11)
    repeat (3) @(posedge mclk);
    rd(3'h6, 8'hf0, 8'hf0);
    wr(3'h1, 8'h01);
    wr(3'h0, 8'h5a);
    rd(3'h5, 8'h20, 8'h61);
    `CHK(irq_out, 1'b0)
    repeat (200) @(posedge mclk);
    rd(3'h5, 8'h61);
    `CHK(irq_out, 1'b1)
    rd(3'h0, 8'h5a);
    wr(3'h4, 8'h00);
    #1 `CHK({irq_out, irq_oe}, 2'b00)
  endtask : t_loop
  task rx_case(input logic [7:0] lc, input logic [7:0] d, input logic p, input logic [7:0] e);
    wr(3'h3, lc);
    i_modem_term.send(d, p);
    rd(3'h5, e);
    rd(3'h0, d);
  endtask : rx_case
  task t_break;
    wr(3'h3, 8'h00);
    i_modem_term.hold_low(200);
    rd(3'h5, 8'h71);
    rd(3'h0, 8'h00);
    rd(3'h5, 8'h60);
  endtask : t_break
  // Low stop bit, then the resync reads idle as a second character
  task t_frame;
    wr(3'h1, 8'h04);
    wr(3'h4, 8'h08);
    wr(3'h3, 8'h00);
    i_modem_term.send(8'h01, 1'b0);
    repeat (160) @(posedge mclk);
    #1 `CHK(irq_out, 1'b1)
    rd(3'h5, 8'h6b);
    rd(3'h0, 8'hff);
    `CHK(irq_out, 1'b0)
  endtask : t_frame
  task t_fifo;
    wr(3'h2, 8'h01);
    wr(3'h3, 8'h18);
    i_modem_term.send(8'h01, 1'b0);
    i_modem_term.send(8'h03, 1'b0);
    rd(3'h5, 8'he5);
    rd(3'h0, 8'h01);
    rd(3'h5, 8'he1);
    rd(3'h5, 8'h61);
    rd(3'h0, 8'h03);
    wr(3'h2, 8'h00);
  endtask : t_fifo
  // Serial cases need about 1900 cycles in all
  always @(posedge mclk) if (++cyc == 6000) begin err_total++; summarize(); end
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    {arst_n, wr_stb, rd_stb, addr, wdata, err_total, comparisons, cyc} = '0;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_control();
    t_modem();
    t_loop();
    rx_case(8'h08, 8'h01, 1'b0, 8'h61);
    rx_case(8'h18, 8'h01, 1'b0, 8'h65);
    rx_case(8'h38, 8'h01, 1'b0, 8'h61);
    rx_case(8'h28, 8'h01, 1'b0, 8'h65);
    t_break();
    t_frame();
    t_fifo();
    summarize();
  end
endmodule : test_uart_line_modem
bind uart_line_modem uart_line_modem_sva i_uart_line_modem_sva (.mclk, .arst_n, .addr, .wdata,
  .wr_stb, .rd_stb, .rdata, .txd, .terminal_ready_out_n, .request_send_out_n, .irq_oe);

// *** bench/uart_line_modem_sva.sv ***
`timescale 1ns/100ps
module uart_line_modem_sva (
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] rdata,
  input wire logic       txd,
  input wire logic       terminal_ready_out_n,
  input wire logic       request_send_out_n,
  input wire logic       irq_oe
);
  // ********
  // Shadow controls, rebuilt from the bus since only ports are seen
  // ********
  logic [7:0] lc_q, lc_d;
  logic [4:0] mc_q, mc_d;
  logic [3:0] loop_view;
  always_comb begin
    lc_d      = (wr_stb && addr == 3'h3) ? wdata : lc_q;
    mc_d      = (wr_stb && addr == 3'h4) ? wdata[4:0] : mc_q;
    loop_view = {mc_q[3:2], mc_q[0], mc_q[1]};
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) {lc_q, mc_q} <= 13'h0000;
    else {lc_q, mc_q} <= {lc_d, mc_d};
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  ready_pin_a: assert property (!mc_q[4] |-> terminal_ready_out_n == !mc_q[0])
    else $error("ready pin wrong");
  request_pin_a: assert property (!mc_q[4] |-> request_send_out_n == !mc_q[1])
    else $error("request pin wrong");
  irq_gate_a: assert property (irq_oe == mc_q[3])
    else $error("irq enable wrong");
  break_hold_a: assert property (lc_q[6] && !mc_q[4] |=> !txd)
    else $error("break not held");
  loop_pins_a: assert property (mc_q[4] |-> terminal_ready_out_n && request_send_out_n)
    else $error("loop pins active");
  loop_mark_a: assert property (mc_q[4] && !lc_q[6] |=> txd)
    else $error("loop txd low");
  modem_read_a: assert property (rd_stb && addr == 3'h4 |=> rdata == {3'h0, $past(mc_q)})
    else $error("modem control readback");
  // Settle window keeps a fresh loop switch out of the check
  loop_status_a: assert property (rd_stb && addr == 3'h6 && mc_q[4] && $past(mc_q, 3) == mc_q
    |=> rdata[7:4] == $past(loop_view)) else $error("loop status wrong");
  cover property (rd_stb && addr == 3'h6 && mc_q[4]);
  cover property (lc_q[6] && !mc_q[4]);
  cover property (rd_stb && addr == 3'h5);
endmodule : uart_line_modem_sva

// *** core/uart_line_modem.sv ***
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
module uart_line_modem
  import uart_lmcs_pkg::*;
#(
  parameter int RX_DEPTH = DEF_RX_DEPTH
) (
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [7:0]        rdata,
  output logic                   txd,
  input  wire logic              rxd,
  input  wire logic              clear_send_in_n,
  input  wire logic              set_ready_in_n,
  input  wire logic              ring_in_n,
  input  wire logic              carrier_detect_in_n,
  output logic                   terminal_ready_out_n,
  output logic                   request_send_out_n,
  output logic                   irq_out,
  output logic                   irq_oe
);

  localparam int PW = $clog2(RX_DEPTH);
  localparam logic [PW:0] CNT_FULL = (PW+1)'(RX_DEPTH);

  // ************************************************************
  // Elaboration check
  // ************************************************************
  // Pointers wrap by overflow, so depth must be a power of two
  if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("RX_DEPTH must be a power of two of at least 2");
  end

  // ************************************************************
  // Reset release and pin synchronisers
  // ************************************************************
  logic [1:0] rst_q;
  logic       rst_n;
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= PIN_SYNC_RST;
      sync2_q <= PIN_SYNC_RST;
    end else begin
      sync1_q <= {carrier_detect_in_n, ring_in_n, set_ready_in_n, clear_send_in_n, rxd};
      sync2_q <= sync1_q;
    end
  end

  // ************************************************************
  // State
  // ************************************************************
  logic [7:0]       line_control_q, line_control_d;
  logic [4:0]       modem_control_q, modem_control_d;
  logic [3:0]       irq_enable_q, irq_enable_d;
  logic [7:0]       div_low_q, div_low_d, div_high_q, div_high_d;
  logic [15:0]      div_cnt_q, div_cnt_d;
  logic             buf_mode_q, buf_mode_d;
  logic [7:0]       tx_holding_q, tx_holding_d;
  logic             hold_full_q, hold_full_d;
  tx_state_e        tx_st_q, tx_st_d;
  logic [3:0]       tx_os_q, tx_os_d;
  logic [2:0]       tx_bit_q, tx_bit_d;
  logic [7:0]       tx_shift_q, tx_shift_d;
  logic             tx_par_q, tx_par_d;
  logic             txd_q, txd_d;
  rx_state_e        rx_st_q, rx_st_d;
  logic [3:0]       rx_os_q, rx_os_d;
  logic [2:0]       rx_bit_q, rx_bit_d;
  logic [7:0]       rx_sh_q, rx_sh_d;
  logic             rx_par_q, rx_par_d;
  logic [PW-1:0]    wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [PW:0]      cnt_q, cnt_d, err_cnt_q, err_cnt_d;
  logic             overrun_q, overrun_d;
  logic [2:0]       head_err_q, head_err_d;
  logic             sum_err_q, sum_err_d;
  logic [3:0]       modem_prev_q, modem_prev_d;
  logic [3:0]       delta_q, delta_d;
  logic             irq_q, irq_d;
  logic [7:0]       rdata_q, rdata_d;
  logic [ENT_W-1:0] mem [RX_DEPTH];

  // ************************************************************
  // Combinational helpers
  // ************************************************************
  logic             div_access, loop_on, tick, tx_line, rx_in;
  logic [15:0]      divisor;
  logic [3:0]       modem_now;
  logic [ENT_W-1:0] head_ent, next_ent, rx_ent, mem_wd;
  logic [PW-1:0]    mem_wa;
  logic             mem_we, rx_done, pop, room, stored, status_read, modem_read;
  logic             brk_now;
  logic [7:0]       line_status;
  logic             receive_ready_flag, tx_holding_empty_flag, tx_all_empty_flag;

  // Constant bit under stick, else odd or even over the data bits
  function automatic logic parity_of(input logic [7:0] d, input logic [7:0] lc);
    if (lc[LC_STICK]) begin
      return ~lc[LC_EVEN_SEL];
    end
    return lc[LC_EVEN_SEL] ? ^d : ~^d;
  endfunction : parity_of

  assign div_access  = line_control_q[LC_DIV_ACCESS];
  assign loop_on     = modem_control_q[MC_LOOP];
  assign divisor     = {div_high_q, div_low_q};
  assign tick        = (div_cnt_q == 16'h0000);
  assign head_ent    = mem[rd_ptr_q];
  assign next_ent    = mem[rd_ptr_q + 1'b1];
  assign status_read = rd_stb && (addr == OFF_LINE_STATUS);
  assign modem_read  = rd_stb && (addr == OFF_MODEM_STATUS);
  // Shared offset: divisor latch or receive data, per access select
  assign pop = rd_stb && (addr == OFF_DATA) && !div_access && (cnt_q != '0);

  // Internal line before break, so break is also seen in loopback
  always_comb begin
    case (tx_st_q)
      TX_START:  tx_line = 1'b0;
      TX_DATA:   tx_line = tx_shift_q[0];
      TX_PARITY: tx_line = tx_par_q;
      default:   tx_line = 1'b1;
    endcase
  end
  assign rx_in = loop_on ? (tx_line & ~line_control_q[LC_BREAK]) : sync2_q[0];

  // Modem inputs: {carrier, ring, set ready, clear send}
  assign modem_now = loop_on ?
    {modem_control_q[MC_OUT_TWO], modem_control_q[MC_OUT_ONE],
     modem_control_q[MC_TERM_READY], modem_control_q[MC_REQ_SEND]} : ~sync2_q[4:1];

  assign receive_ready_flag    = (cnt_q != '0);
  assign tx_holding_empty_flag = ~hold_full_q;
  assign tx_all_empty_flag     = ~hold_full_q && (tx_st_q == TX_IDLE);
  assign line_status = {buf_mode_q & sum_err_q, tx_all_empty_flag, tx_holding_empty_flag,
                        head_err_q[2], head_err_q[1], head_err_q[0], overrun_q,
                        receive_ready_flag};

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    line_control_d  = line_control_q;
    modem_control_d = modem_control_q;
    irq_enable_d    = irq_enable_q;
    div_low_d       = div_low_q;
    div_high_d      = div_high_q;
    buf_mode_d      = buf_mode_q;
    tx_holding_d    = tx_holding_q;
    hold_full_d     = hold_full_q;
    tx_st_d         = tx_st_q;
    tx_os_d         = tx_os_q;
    tx_bit_d        = tx_bit_q;
    tx_shift_d      = tx_shift_q;
    tx_par_d        = tx_par_q;
    rx_st_d         = rx_st_q;
    rx_os_d         = rx_os_q;
    rx_bit_d        = rx_bit_q;
    rx_sh_d         = rx_sh_q;
    rx_par_d        = rx_par_q;
    wr_ptr_d        = wr_ptr_q;
    rd_ptr_d        = rd_ptr_q;
    cnt_d           = cnt_q;
    err_cnt_d       = err_cnt_q;
    rx_done         = 1'b0;
    rx_ent          = '0;
    brk_now         = 1'b0;
    mem_we          = 1'b0;
    mem_wa          = wr_ptr_q;
    div_cnt_d       = tick ? ((divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001)
                           : div_cnt_q - 16'h0001;

    // Transmitter
    if (tick && tx_st_q != TX_IDLE) begin
      tx_os_d = tx_os_q + 4'h1;
    end
    case (tx_st_q)
      TX_IDLE: begin
        if (hold_full_q) begin
          tx_shift_d  = tx_holding_q;
          tx_par_d    = parity_of(tx_holding_q, line_control_q);
          hold_full_d = 1'b0;
          tx_os_d     = 4'h0;
          tx_st_d     = TX_START;
        end
      end
      TX_START: begin
        if (tick && tx_os_q == OS_LAST) begin
          tx_st_d  = TX_DATA;
          tx_bit_d = 3'h0;
        end
      end
      TX_DATA: begin
        if (tick && tx_os_q == OS_LAST) begin
          tx_shift_d = tx_shift_q >> 1;
          tx_bit_d   = tx_bit_q + 3'h1;
          if (tx_bit_q == DATA_LAST) begin
            tx_st_d = line_control_q[LC_PARITY_EN] ? TX_PARITY : TX_STOP;
          end
        end
      end
      TX_PARITY: begin
        if (tick && tx_os_q == OS_LAST) begin
          tx_st_d = TX_STOP;
        end
      end
      TX_STOP: begin
        if (tick && tx_os_q == OS_LAST) begin
          tx_st_d = TX_IDLE;
        end
      end
      default: tx_st_d = TX_IDLE;
    endcase

    // Receiver, sampling mid-bit at 16x
    if (tick && rx_st_q != RX_IDLE) begin
      rx_os_d = rx_os_q + 4'h1;
    end
    case (rx_st_q)
      RX_IDLE: begin
        if (tick && !rx_in) begin
          rx_st_d = RX_START;
          rx_os_d = 4'h0;
        end
      end
      RX_START: begin
        if (tick && rx_os_q == OS_MID) begin
          rx_st_d  = rx_in ? RX_IDLE : RX_DATA;
          rx_os_d  = 4'h0;
          rx_bit_d = 3'h0;
        end
      end
      RX_DATA: begin
        if (tick && rx_os_q == OS_LAST) begin
          rx_sh_d  = {rx_in, rx_sh_q[7:1]};
          rx_bit_d = rx_bit_q + 3'h1;
          if (rx_bit_q == DATA_LAST) begin
            rx_st_d = line_control_q[LC_PARITY_EN] ? RX_PARITY : RX_STOP;
          end
        end
      end
      RX_PARITY: begin
        if (tick && rx_os_q == OS_LAST) begin
          rx_par_d = rx_in;
          rx_st_d  = RX_STOP;
        end
      end
      RX_STOP: begin
        if (tick && rx_os_q == OS_LAST) begin
          rx_done = 1'b1;
          brk_now = (rx_sh_q == 8'h00) && !rx_in &&
                    !(line_control_q[LC_PARITY_EN] && rx_par_q);
          rx_ent[7:0]     = rx_sh_q;
          rx_ent[ENT_BRK] = brk_now;
          rx_ent[ENT_FRM] = !rx_in && !brk_now;
          rx_ent[ENT_PAR] = line_control_q[LC_PARITY_EN] && !brk_now &&
                            (rx_par_q != parity_of(rx_sh_q, line_control_q));
          rx_os_d  = 4'h0;
          rx_bit_d = 3'h0;
          if (brk_now) begin
            rx_st_d = RX_BREAK;
          end else if (!rx_in) begin
            rx_st_d = RX_DATA;
          end else begin
            rx_st_d = RX_IDLE;
          end
        end
      end
      RX_BREAK: begin
        // Only one character per break; wait for half a bit of marking
        if (tick) begin
          rx_os_d = rx_in ? rx_os_q + 4'h1 : 4'h0;
          if (rx_in && rx_os_q == HALF_BIT_TICKS - 4'h1) begin
            rx_st_d = RX_IDLE;
          end
        end
      end
      default: rx_st_d = RX_IDLE;
    endcase

    // Receive buffer; depth one when unbuffered
    room   = (buf_mode_q ? (cnt_q != CNT_FULL) : (cnt_q == '0)) || pop;
    stored = rx_done && room;
    mem_wd = rx_ent;
    if (stored) begin
      mem_we   = 1'b1;
      wr_ptr_d = wr_ptr_q + 1'b1;
    end else if (rx_done && !buf_mode_q) begin
      mem_we = 1'b1;
      mem_wa = rd_ptr_q;
    end
    if (pop) begin
      rd_ptr_d = rd_ptr_q + 1'b1;
    end
    if (stored && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !stored) begin
      cnt_d = cnt_q - 1'b1;
    end
    if (stored && buf_mode_q && (|rx_ent[ENT_BRK:ENT_PAR]) &&
        !(pop && (|head_ent[ENT_BRK:ENT_PAR]))) begin
      err_cnt_d = err_cnt_q + 1'b1;
    end else if (pop && (|head_ent[ENT_BRK:ENT_PAR]) &&
                 !(stored && buf_mode_q && (|rx_ent[ENT_BRK:ENT_PAR]))) begin
      err_cnt_d = err_cnt_q - 1'b1;
    end

    // Error flags follow the character that reaches the head
    overrun_d  = (rx_done && !room) || (overrun_q && !status_read);
    head_err_d = head_err_q & {3{!status_read}};
    if (rx_done && (!buf_mode_q || cnt_q == '0 || (pop && cnt_q == 1))) begin
      head_err_d = head_err_d | rx_ent[ENT_BRK:ENT_PAR];
    end else if (pop && cnt_q > 1) begin
      head_err_d = head_err_d | next_ent[ENT_BRK:ENT_PAR];
    end
    sum_err_d = (stored && buf_mode_q && (|rx_ent[ENT_BRK:ENT_PAR])) ||
                (sum_err_q && !(status_read && err_cnt_d == '0));

    // Register writes
    if (wr_stb) begin
      case (addr)
        OFF_DATA: begin
          if (div_access) begin
            div_low_d = wdata;
          end else begin
            tx_holding_d = wdata;
            hold_full_d  = 1'b1;
          end
        end
        OFF_IRQ_ENABLE: begin
          if (div_access) begin
            div_high_d = wdata;
          end else begin
            irq_enable_d = wdata[3:0];
          end
        end
        OFF_BUFFER_MODE:   buf_mode_d      = wdata[0];
        OFF_LINE_CONTROL:  line_control_d  = wdata;
        OFF_MODEM_CONTROL: modem_control_d = wdata[4:0];
        default: ;
      endcase
    end
    // Changing buffer mode empties the receive buffer
    if (buf_mode_d != buf_mode_q) begin
      wr_ptr_d  = '0;
      rd_ptr_d  = '0;
      cnt_d     = '0;
      err_cnt_d = '0;
      sum_err_d = 1'b0;
    end
    // Reloading a latch restarts the baud count at once
    if (wr_stb && div_access && (addr == OFF_DATA || addr == OFF_IRQ_ENABLE)) begin
      div_cnt_d = 16'h0000;
    end

    // Modem change detection, set wins over the read clear
    modem_prev_d = modem_now;
    delta_d[0]   = (modem_now[0] ^ modem_prev_q[0]) || (delta_q[0] && !modem_read);
    delta_d[1]   = (modem_now[1] ^ modem_prev_q[1]) || (delta_q[1] && !modem_read);
    delta_d[2]   = (modem_prev_q[2] && !modem_now[2]) || (delta_q[2] && !modem_read);
    delta_d[3]   = (modem_now[3] ^ modem_prev_q[3]) || (delta_q[3] && !modem_read);

    irq_d = (irq_enable_q[IE_RX_DATA] && receive_ready_flag) ||
            (irq_enable_q[IE_TX_EMPTY] && tx_holding_empty_flag) ||
            (irq_enable_q[IE_LINE] && (overrun_q || (|head_err_q))) ||
            (irq_enable_q[IE_MODEM] && (|delta_q));

    // Loopback marks the line; break overrides transmitter activity
    txd_d = loop_on ? 1'b1 : (line_control_q[LC_BREAK] ? 1'b0 : tx_line);

    rdata_d = 8'h00;
    if (rd_stb) begin
      case (addr)
        OFF_DATA:          rdata_d = div_access ? div_low_q : head_ent[7:0];
        OFF_IRQ_ENABLE:    rdata_d = div_access ? div_high_q : {4'h0, irq_enable_q};
        OFF_BUFFER_MODE:   rdata_d = {7'h00, buf_mode_q};
        OFF_LINE_CONTROL:  rdata_d = line_control_q;
        OFF_MODEM_CONTROL: rdata_d = {3'h0, modem_control_q};
        OFF_LINE_STATUS:   rdata_d = line_status;
        OFF_MODEM_STATUS:  rdata_d = {modem_now, delta_q};
        default:           rdata_d = 8'h00;
      endcase
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      line_control_q  <= LINE_CONTROL_RST;
      modem_control_q <= MODEM_CONTROL_RST;
      irq_enable_q    <= IRQ_ENABLE_RST;
      div_low_q       <= DIVISOR_RST[7:0];
      div_high_q      <= DIVISOR_RST[15:8];
      div_cnt_q       <= 16'h0000;
      buf_mode_q      <= 1'b0;
      tx_holding_q    <= 8'h00;
      hold_full_q     <= 1'b0;
      tx_st_q         <= TX_IDLE;
      tx_os_q         <= 4'h0;
      tx_bit_q        <= 3'h0;
      tx_shift_q      <= 8'h00;
      tx_par_q        <= 1'b0;
      txd_q           <= 1'b1;
      rx_st_q         <= RX_IDLE;
      rx_os_q         <= 4'h0;
      rx_bit_q        <= 3'h0;
      rx_sh_q         <= 8'h00;
      rx_par_q        <= 1'b0;
      wr_ptr_q        <= '0;
      rd_ptr_q        <= '0;
      cnt_q           <= '0;
      err_cnt_q       <= '0;
      overrun_q       <= 1'b0;
      head_err_q      <= 3'h0;
      sum_err_q       <= 1'b0;
      modem_prev_q    <= 4'h0;
      delta_q         <= 4'h0;
      irq_q           <= 1'b0;
      rdata_q         <= 8'h00;
    end else begin
      line_control_q  <= line_control_d;
      modem_control_q <= modem_control_d;
      irq_enable_q    <= irq_enable_d;
      div_low_q       <= div_low_d;
      div_high_q      <= div_high_d;
      div_cnt_q       <= div_cnt_d;
      buf_mode_q      <= buf_mode_d;
      tx_holding_q    <= tx_holding_d;
      hold_full_q     <= hold_full_d;
      tx_st_q         <= tx_st_d;
      tx_os_q         <= tx_os_d;
      tx_bit_q        <= tx_bit_d;
      tx_shift_q      <= tx_shift_d;
      tx_par_q        <= tx_par_d;
      txd_q           <= txd_d;
      rx_st_q         <= rx_st_d;
      rx_os_q         <= rx_os_d;
      rx_bit_q        <= rx_bit_d;
      rx_sh_q         <= rx_sh_d;
      rx_par_q        <= rx_par_d;
      wr_ptr_q        <= wr_ptr_d;
      rd_ptr_q        <= rd_ptr_d;
      cnt_q           <= cnt_d;
      err_cnt_q       <= err_cnt_d;
      overrun_q       <= overrun_d;
      head_err_q      <= head_err_d;
      sum_err_q       <= sum_err_d;
      modem_prev_q    <= modem_prev_d;
      delta_q         <= delta_d;
      irq_q           <= irq_d;
      rdata_q         <= rdata_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign rdata                = rdata_q;
  assign txd                  = txd_q;
  // Ready and request pins forced inactive high in loopback; the interrupt pins still follow out two
  assign terminal_ready_out_n = loop_on | ~modem_control_q[MC_TERM_READY];
  assign request_send_out_n   = loop_on | ~modem_control_q[MC_REQ_SEND];
  assign irq_oe               = modem_control_q[MC_OUT_TWO];
  assign irq_out              = irq_q & modem_control_q[MC_OUT_TWO];

endmodule : uart_line_modem

// *** core/uart_lmcs_pkg.sv ***
package uart_lmcs_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam int         ADDR_W            = 3;
  localparam logic [2:0] OFF_DATA          = 3'h0;
  localparam logic [2:0] OFF_IRQ_ENABLE    = 3'h1;
  localparam logic [2:0] OFF_BUFFER_MODE   = 3'h2;
  localparam logic [2:0] OFF_LINE_CONTROL  = 3'h3;
  localparam logic [2:0] OFF_MODEM_CONTROL = 3'h4;
  localparam logic [2:0] OFF_LINE_STATUS   = 3'h5;
  localparam logic [2:0] OFF_MODEM_STATUS  = 3'h6;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int LC_PARITY_EN  = 3;
  localparam int LC_EVEN_SEL   = 4;
  localparam int LC_STICK      = 5;
  localparam int LC_BREAK      = 6;
  localparam int LC_DIV_ACCESS = 7;
  localparam int MC_TERM_READY = 0;
  localparam int MC_REQ_SEND   = 1;
  localparam int MC_OUT_ONE    = 2;
  localparam int MC_OUT_TWO    = 3;
  localparam int MC_LOOP       = 4;
  localparam int IE_RX_DATA    = 0;
  localparam int IE_TX_EMPTY   = 1;
  localparam int IE_LINE       = 2;
  localparam int IE_MODEM      = 3;
  localparam int ENT_PAR       = 8;
  localparam int ENT_FRM       = 9;
  localparam int ENT_BRK       = 10;
  localparam int ENT_W         = 11;

  // ************************************************************
  // Reset values and counts
  // ************************************************************
  localparam logic [7:0]  LINE_CONTROL_RST  = 8'h00;
  localparam logic [4:0]  MODEM_CONTROL_RST = 5'h00;
  localparam logic [3:0]  IRQ_ENABLE_RST    = 4'h0;
  localparam logic [15:0] DIVISOR_RST       = 16'h0001;
  localparam logic [4:0]  PIN_SYNC_RST      = 5'h1f;
  localparam logic [3:0]  OS_LAST           = 4'hf;
  localparam logic [3:0]  OS_MID            = 4'h7;
  localparam logic [3:0]  HALF_BIT_TICKS    = 4'h8;
  localparam logic [2:0]  DATA_LAST         = 3'h7;
  localparam int          DEF_RX_DEPTH      = 16;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_BREAK} rx_state_e;

endpackage : uart_lmcs_pkg
